// File: hw/pmd_pkg.sv
// Constants of the diagnostic flag, alert and result register block
// How it works
// - Current result: read-only 16-bit two's complement, resets to zero.
// - Power result: read-only 24-bit unsigned, resets to zero.
// - Latch bit zero: alert and flags drop once the fault goes away.
// - Latch bit one: alert and flags hold until diagnostic register read.
// - Conversion-ready enable puts conversion-complete flag on the alert.
// - Averaged select picks raw or averaged values for limit comparisons.
// - Polarity bit: open-drain alert active-low at zero, active-high at one.
// - Reserved diagnostic bits 11, 10 and 8 read zero, ignore writes.
// - Math overflow flag sets on arithmetic overflow; results may be invalid.
// - Math overflow flag holds until a new conversion is triggered.
// - Temperature flag sets when temperature exceeds its limit.
// - Shunt over flag sets when shunt voltage exceeds its upper limit.
// - Shunt under flag sets when shunt voltage falls below its limit.
// - Bus over flag sets when bus voltage exceeds its upper limit.
// - Bus under flag sets when bus voltage falls below its lower limit.
// - Power flag sets when power exceeds the power limit.
// - In latch mode a diagnostic read clears every set limit flag.
// - Conversion flag sets on completion; new start, or read in latch mode, clears it.
// - Memory status reads one; checksum error clears it to zero.
// - Diagnostic register resets to 0x0001.
// - Results update only after the whole averaging sequence completes.
// - Shunt calibration sets current scaling upstream of this register.
package pmd_pkg;
    // Register offsets
    localparam logic [5:0] PMD_OFS_CURRENT = 6'h07;
    localparam logic [5:0] PMD_OFS_POWER   = 6'h08;
    localparam logic [5:0] PMD_OFS_DIAG    = 6'h0b;
    // Widths
    localparam int PMD_ADDR_W = 6;
    localparam int PMD_DATA_W = 24;
    localparam int PMD_CUR_W  = 16;
    localparam int PMD_PWR_W  = 24;
    localparam int PMD_DIAG_W = 16;
    localparam int PMD_MEAS_W = 16;
    localparam int PMD_NLIM   = 6;
    // Diagnostic register bit positions
    localparam int PMD_B_LATCH  = 15;
    localparam int PMD_B_CONV_READY_ALERT_EN   = 14;
    localparam int PMD_B_AVGSEL = 13;
    localparam int PMD_B_POL    = 12;
    localparam int PMD_B_MATH_OVERFLOW_FLAG = 9;
    localparam int PMD_B_TEMP   = 7;
    localparam int PMD_B_LIMLO  = 2;
    localparam int PMD_B_CONV_COMPLETE_FLAG  = 1;
    localparam int PMD_B_MEMOK  = 0;
    // Limit flag order within the limit vector (LSB = bit 2)
    localparam int PMD_L_POWER  = 0;
    localparam int PMD_L_BUS_UNDER_FLAG  = 1;
    localparam int PMD_L_BUS_OVER_FLAG  = 2;
    localparam int PMD_L_SHUNT_UNDER_FLAG = 3;
    localparam int PMD_L_SHUNT_OVER_FLAG = 4;
    localparam int PMD_L_TEMP   = 5;
    // Reset values
    localparam logic [15:0] PMD_DIAG_RST = 16'h0001;
    localparam logic [15:0] PMD_CUR_RST  = 16'h0000;
    localparam logic [23:0] PMD_PWR_RST  = 24'h000000;
    // Power limit is compared against power divided by 256
    localparam int PMD_PWR_LIM_SHIFT = 8;
endpackage : pmd_pkg

// File: hw/pmd_limit_cmp.sv
// Limit comparators for temperature, shunt, bus and power
`timescale 1ns/1ps
`default_nettype none
module pmd_limit_cmp #(
    parameter int MEAS_W = 16,
    parameter int PWR_W  = 24
) (
    input  wire logic [MEAS_W-1:0] temp_val,
    input  wire logic [MEAS_W-1:0] shunt_val,
    input  wire logic [MEAS_W-1:0] bus_val,
    input  wire logic [PWR_W-1:0]  power_val,
    input  wire logic [MEAS_W-1:0] temp_lim,
    input  wire logic [MEAS_W-1:0] shunt_over_lim,
    input  wire logic [MEAS_W-1:0] shunt_under_lim,
    input  wire logic [MEAS_W-1:0] bus_over_lim,
    input  wire logic [MEAS_W-1:0] bus_under_lim,
    input  wire logic [MEAS_W-1:0] power_lim,
    output logic      [5:0]        over_under
);
    import pmd_pkg::*;

    // Signed greater-than, shared by temperature and shunt checks
    function automatic logic sgt(input logic [MEAS_W-1:0] a,
                                 input logic [MEAS_W-1:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction : sgt

    // Bus values are positive-only, so unsigned compare is exact
    always_comb begin
        over_under = '0;
        over_under[PMD_L_TEMP]   = sgt(temp_val, temp_lim);
        over_under[PMD_L_SHUNT_OVER_FLAG] = sgt(shunt_val, shunt_over_lim);
        over_under[PMD_L_SHUNT_UNDER_FLAG] = sgt(shunt_under_lim, shunt_val);
        over_under[PMD_L_BUS_OVER_FLAG]  = bus_val > bus_over_lim;
        over_under[PMD_L_BUS_UNDER_FLAG]  = bus_val < bus_under_lim;
        // Limit LSB is 256 power LSBs
        over_under[PMD_L_POWER]  =
            power_val[PWR_W-1:PMD_PWR_LIM_SHIFT] > power_lim;
    end
endmodule : pmd_limit_cmp
`default_nettype wire

// File: hw/pmd_flag_cell.sv
// One limit flag with transparent or latched behaviour
`timescale 1ns/1ps
`default_nettype none
module pmd_flag_cell (
    input  wire logic REF_CLK,
    input  wire logic NRST,
    input  wire logic update,
    input  wire logic cond,
    input  wire logic latch_mode,
    input  wire logic rd_clr,
    output logic      flag
);
    logic flag_reg;

    // Latched: a new fault wins over the read that clears it
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            flag_reg <= 1'b0;
        end else if (!latch_mode) begin
            if (update) begin
                flag_reg <= cond;
            end
        end else if (update && cond) begin
            flag_reg <= 1'b1;
        end else if (rd_clr) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag = flag_reg;
endmodule : pmd_flag_cell
`default_nettype wire

// File: hw/pmd_diag_alert.sv
// Diagnostic flags, alert pin and current/power result registers
`timescale 1ns/1ps
`default_nettype none
module pmd_diag_alert (
    input  wire logic                       REF_CLK,
    input  wire logic                       NRST,
    // Register access from the serial host interface
    input  wire logic [pmd_pkg::PMD_ADDR_W-1:0] REG_ADDR,
    input  wire logic                       REG_RD,
    input  wire logic                       REG_WR,
    input  wire logic [pmd_pkg::PMD_DATA_W-1:0] REG_WDATA,
    output logic      [pmd_pkg::PMD_DATA_W-1:0] REG_RDATA,
    output logic                            REG_RVALID,
    // Raw ADC samples
    input  wire logic                       RAW_VALID,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] TEMP_RAW,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] SHUNT_RAW,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] BUS_RAW,
    // Averaged samples, valid at end of averaging
    input  wire logic                       AVG_VALID,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] TEMP_AVG,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] SHUNT_AVG,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] BUS_AVG,
    // Limits from the threshold registers
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] TEMP_LIM,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] SHUNT_OVER_LIM,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] SHUNT_UNDER_LIM,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] BUS_OVER_LIM,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] BUS_UNDER_LIM,
    input  wire logic [pmd_pkg::PMD_MEAS_W-1:0] POWER_LIM,
    // Arithmetic results, valid once averaging completes
    input  wire logic                       RESULT_VALID,
    input  wire logic [pmd_pkg::PMD_CUR_W-1:0]  CURRENT_IN,
    input  wire logic [pmd_pkg::PMD_PWR_W-1:0]  POWER_IN,
    // Conversion and fault events
    input  wire logic                       CONV_START,
    input  wire logic                       CONV_DONE,
    input  wire logic                       MATH_OVF_EVT,
    input  wire logic                       CHECKSUM_ERR,
    // Open-drain alert pin
    output logic                            ALERT_O,
    output logic                            ALERT_OE
);
    import pmd_pkg::*;

    logic                  alert_latch_mode_reg;
    logic                  conv_ready_alert_en_reg;
    logic                  averaged_compare_sel_reg;
    logic                  alert_polarity_reg;
    logic                  math_overflow_flag_reg;
    logic                  conv_complete_flag_reg;
    logic                  trim_checksum_ok_reg;
    logic [PMD_CUR_W-1:0]  current_result_reg;
    logic [PMD_PWR_W-1:0]  power_result_reg;
    logic [PMD_DATA_W-1:0] rdata_reg;
    logic                  rvalid_reg;
    logic                  alert_active_reg;
    logic                  alert_oe_reg;
    logic [PMD_NLIM-1:0]   lim_cond;
    logic [PMD_NLIM-1:0]   lim_flag;
    logic [PMD_NLIM-1:0]   lim_update;
    logic [PMD_MEAS_W-1:0] temp_sel;
    logic [PMD_MEAS_W-1:0] shunt_sel;
    logic [PMD_MEAS_W-1:0] bus_sel;
    logic                  meas_update;
    logic                  diag_hit;
    logic                  diag_rd;
    logic                  diag_wr;
    logic [PMD_DIAG_W-1:0] diag_value;
    logic                  alert_next;

    // Register decode
    function automatic logic hit(input logic [PMD_ADDR_W-1:0] a,
                                 input logic [PMD_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign diag_hit = hit(REG_ADDR, PMD_OFS_DIAG);
    assign diag_rd  = REG_RD && diag_hit;
    assign diag_wr  = REG_WR && diag_hit;

    // Comparison source; averaged mode waits for the averaged strobe
    assign temp_sel    = averaged_compare_sel_reg ? TEMP_AVG  : TEMP_RAW;
    assign shunt_sel   = averaged_compare_sel_reg ? SHUNT_AVG : SHUNT_RAW;
    assign bus_sel     = averaged_compare_sel_reg ? BUS_AVG   : BUS_RAW;
    assign meas_update = averaged_compare_sel_reg ? AVG_VALID : RAW_VALID;

    pmd_limit_cmp #(
        .MEAS_W (PMD_MEAS_W),
        .PWR_W  (PMD_PWR_W)
    ) u_cmp (
        .temp_val        (temp_sel),
        .shunt_val       (shunt_sel),
        .bus_val         (bus_sel),
        .power_val       (POWER_IN),
        .temp_lim        (TEMP_LIM),
        .shunt_over_lim  (SHUNT_OVER_LIM),
        .shunt_under_lim (SHUNT_UNDER_LIM),
        .bus_over_lim    (BUS_OVER_LIM),
        .bus_under_lim   (BUS_UNDER_LIM),
        .power_lim       (POWER_LIM),
        .over_under      (lim_cond)
    );

    // Power exists only as a computed result, so it updates on results
    always_comb begin
        lim_update = {PMD_NLIM{meas_update}};
        lim_update[PMD_L_POWER] = RESULT_VALID;
    end

    // One cell per limit flag
    for (genvar i = 0; i < PMD_NLIM; i++) begin : g_lim
        pmd_flag_cell u_flag (
            .REF_CLK    (REF_CLK),
            .NRST       (NRST),
            .update     (lim_update[i]),
            .cond       (lim_cond[i]),
            .latch_mode (alert_latch_mode_reg),
            .rd_clr     (diag_rd),
            .flag       (lim_flag[i])
        );
    end

    // Control bits; flag and reserved bits ignore writes
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            alert_latch_mode_reg     <= PMD_DIAG_RST[PMD_B_LATCH];
            conv_ready_alert_en_reg  <= PMD_DIAG_RST[PMD_B_CONV_READY_ALERT_EN];
            averaged_compare_sel_reg <= PMD_DIAG_RST[PMD_B_AVGSEL];
            alert_polarity_reg       <= PMD_DIAG_RST[PMD_B_POL];
        end else if (diag_wr) begin
            alert_latch_mode_reg     <= REG_WDATA[PMD_B_LATCH];
            conv_ready_alert_en_reg  <= REG_WDATA[PMD_B_CONV_READY_ALERT_EN];
            averaged_compare_sel_reg <= REG_WDATA[PMD_B_AVGSEL];
            alert_polarity_reg       <= REG_WDATA[PMD_B_POL];
        end
    end

    // Overflow holds until a new conversion; a fresh overflow wins
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            math_overflow_flag_reg <= PMD_DIAG_RST[PMD_B_MATH_OVERFLOW_FLAG];
        end else if (MATH_OVF_EVT) begin
            math_overflow_flag_reg <= 1'b1;
        end else if (CONV_START) begin
            math_overflow_flag_reg <= 1'b0;
        end
    end

    // Conversion complete; read clears only in latch mode
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            conv_complete_flag_reg <= PMD_DIAG_RST[PMD_B_CONV_COMPLETE_FLAG];
        end else if (CONV_DONE) begin
            conv_complete_flag_reg <= 1'b1;
        end else if (CONV_START) begin
            conv_complete_flag_reg <= 1'b0;
        end else if (diag_rd && alert_latch_mode_reg) begin
            conv_complete_flag_reg <= 1'b0;
        end
    end

    // Checksum failure is permanent until reset
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            trim_checksum_ok_reg <= PMD_DIAG_RST[PMD_B_MEMOK];
        end else if (CHECKSUM_ERR) begin
            trim_checksum_ok_reg <= 1'b0;
        end
    end

    // Results; scaling by the calibration constant is done upstream
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            current_result_reg <= PMD_CUR_RST;
            power_result_reg   <= PMD_PWR_RST;
        end else if (RESULT_VALID) begin
            current_result_reg <= CURRENT_IN;
            power_result_reg   <= POWER_IN;
        end
    end

    // Diagnostic word; reserved bits stay zero
    always_comb begin
        diag_value                = '0;
        diag_value[PMD_B_LATCH]   = alert_latch_mode_reg;
        diag_value[PMD_B_CONV_READY_ALERT_EN]    = conv_ready_alert_en_reg;
        diag_value[PMD_B_AVGSEL]  = averaged_compare_sel_reg;
        diag_value[PMD_B_POL]     = alert_polarity_reg;
        diag_value[PMD_B_MATH_OVERFLOW_FLAG]  = math_overflow_flag_reg;
        diag_value[PMD_B_TEMP:PMD_B_LIMLO] = lim_flag;
        diag_value[PMD_B_CONV_COMPLETE_FLAG]   = conv_complete_flag_reg;
        diag_value[PMD_B_MEMOK]   = trim_checksum_ok_reg;
    end

    // Read data sampled before the read-clear lands
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= REG_RD;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    PMD_OFS_CURRENT: rdata_reg <= {8'h00, current_result_reg};
                    PMD_OFS_POWER:   rdata_reg <= power_result_reg;
                    PMD_OFS_DIAG:    rdata_reg <= {8'h00, diag_value};
                    default:         rdata_reg <= '0;
                endcase
            end
        end
    end

    // Alert source combines every fault and the optional ready flag
    assign alert_next = (|lim_flag) || math_overflow_flag_reg
                     || !trim_checksum_ok_reg
                     || (conv_complete_flag_reg
                         && conv_ready_alert_en_reg);

    // Open drain: drive low when active-low alert is on, or when an
    // active-high alert is off; never drives high
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            alert_active_reg <= 1'b0;
            alert_oe_reg     <= 1'b0;
        end else begin
            alert_active_reg <= alert_next;
            alert_oe_reg     <= alert_next ^ alert_polarity_reg;
        end
    end

    assign ALERT_O    = 1'b0;
    assign ALERT_OE   = alert_oe_reg;
    assign REG_RDATA  = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    // Checks
    a_current_capture: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        RESULT_VALID |=> current_result_reg == $past(CURRENT_IN))
        else $error("current result not captured");

    a_power_capture: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        !RESULT_VALID |=> $stable(power_result_reg))
        else $error("power result changed without a result");

    a_transp_follow: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (!alert_latch_mode_reg && meas_update) |=>
            lim_flag[PMD_L_TEMP] == $past(lim_cond[PMD_L_TEMP]))
        else $error("transparent flag does not follow condition");

    a_latch_hold: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (alert_latch_mode_reg && lim_flag[PMD_L_SHUNT_OVER_FLAG] && !diag_rd
         && !diag_wr) |=> lim_flag[PMD_L_SHUNT_OVER_FLAG])
        else $error("latched flag dropped without a read");

    a_ready_alert: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (conv_complete_flag_reg && conv_ready_alert_en_reg)
            |=> alert_active_reg)
        else $error("ready flag missing on alert");

    a_alert_pin: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        ##1 (ALERT_OE == (alert_active_reg ^ $past(alert_polarity_reg))
             && ALERT_O == 1'b0))
        else $error("alert pin polarity wrong");

    a_reserved_zero: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (REG_RD && diag_hit) |=>
            REG_RVALID && REG_RDATA[11:10] == 2'b00 && !REG_RDATA[8])
        else $error("reserved diagnostic bits not zero");

    a_ovf_set: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        MATH_OVF_EVT |=> math_overflow_flag_reg)
        else $error("overflow flag not set");

    a_ovf_clear: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (math_overflow_flag_reg && CONV_START && !MATH_OVF_EVT)
            |=> !math_overflow_flag_reg ##1 1'b1)
        else $error("overflow flag not cleared by conversion");

    a_rd_clear: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (alert_latch_mode_reg && diag_rd && !CONV_DONE && !diag_wr)
            |=> !conv_complete_flag_reg)
        else $error("read did not clear conversion flag");

    a_limit_rdclr: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (alert_latch_mode_reg && diag_rd && !diag_wr && !RESULT_VALID)
            |=> !lim_flag[PMD_L_POWER])
        else $error("read did not clear power flag");

    a_mem_error: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        CHECKSUM_ERR |=> !trim_checksum_ok_reg ##1 alert_active_reg)
        else $error("checksum error not reported");

    // Raw strobes must not move a flag while averaged values are selected
    a_avg_hold: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (averaged_compare_sel_reg && !AVG_VALID && !diag_rd)
            |=> $stable(lim_flag[PMD_L_TEMP]))
        else $error("raw sample moved flag in averaged mode");

    a_alert_any: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (|lim_flag || math_overflow_flag_reg || !trim_checksum_ok_reg)
            |=> alert_active_reg)
        else $error("fault flag missing on alert");

    a_power_set: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (alert_latch_mode_reg && RESULT_VALID && lim_cond[PMD_L_POWER])
            |=> lim_flag[PMD_L_POWER])
        else $error("power flag not set on over-limit result");
endmodule : pmd_diag_alert
`default_nettype wire

// File: verif/pmd_host_model.sv
// Host controller model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmd_host_model
    import pmd_pkg::*;
(
    input  wire logic                  REF_CLK,
    output logic      [PMD_ADDR_W-1:0] addr,
    output logic                       rd,
    output logic                       wr,
    output logic      [PMD_DATA_W-1:0] wdata,
    input  wire logic [PMD_DATA_W-1:0] rdata,
    input  wire logic                  rvalid
);
    // Idle bus at time zero
    initial begin
        addr  = '0;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = '0;
    end
    // Read strobe for one cycle; answer is taken on the following edge
    task automatic read_reg(input logic [PMD_ADDR_W-1:0] a,
                            output logic [PMD_DATA_W-1:0] d);
        @(posedge REF_CLK);
        #1;
        addr = a;
        rd   = 1'b1;
        @(posedge REF_CLK);
        #1;
        rd = 1'b0;
        d  = rvalid ? rdata : 'x; // A missing answer never passes
    endtask : read_reg
    // Write strobe for one cycle; data scrambled afterwards, no kinder
    task automatic write_reg(input logic [PMD_ADDR_W-1:0] a,
                             input logic [PMD_DATA_W-1:0] d);
        @(posedge REF_CLK);
        #1;
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(posedge REF_CLK);
        #1;
        wr    = 1'b0;
        wdata = ~d;
    endtask : write_reg
endmodule : pmd_host_model
`default_nettype wire

// File: verif/power_monitor_diag_alert_results_test.sv
// Self-checking bench for the diagnostic flag and alert block
`timescale 1ns/1ps
`default_nettype none
module power_monitor_diag_alert_results_test;
    import pmd_pkg::*;
    localparam logic [47:0] RAW_NORM = 48'h0000_0000_0050;
    localparam logic [47:0] RAW_TBL [5] = '{48'h0200_0000_0050,
        48'h0000_0200_0050, 48'h0000_fe00_0050, 48'h0000_0000_0200, 48'h0};
    logic                  REF_CLK, NRST, REG_RD, REG_WR, REG_RVALID;
    logic                  ALERT_O, ALERT_OE;
    logic [6:0]            ev; // avg,result,cksum,ovf,done,start,raw
    logic [PMD_ADDR_W-1:0] REG_ADDR;
    logic [PMD_DATA_W-1:0] REG_WDATA, REG_RDATA;
    logic [PMD_PWR_W-1:0]  POWER_IN;
    logic [PMD_MEAS_W-1:0] TEMP_RAW, SHUNT_RAW, BUS_RAW, TEMP_AVG, CURRENT_IN;
    logic [PMD_MEAS_W-1:0] TEMP_LIM, SHUNT_OVER_LIM, SHUNT_UNDER_LIM;
    logic [PMD_MEAS_W-1:0] BUS_OVER_LIM, BUS_UNDER_LIM, POWER_LIM;
    int                    failures, checks;
    // Device under test and the host on its register port
    pmd_diag_alert uut (.REF_CLK(REF_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
        .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .RAW_VALID(ev[0]),
        .TEMP_RAW(TEMP_RAW), .SHUNT_RAW(SHUNT_RAW), .BUS_RAW(BUS_RAW),
        .AVG_VALID(ev[6]), .TEMP_AVG(TEMP_AVG), .SHUNT_AVG(SHUNT_RAW),
        .BUS_AVG(BUS_RAW), .TEMP_LIM(TEMP_LIM),
        .SHUNT_OVER_LIM(SHUNT_OVER_LIM), .SHUNT_UNDER_LIM(SHUNT_UNDER_LIM),
        .BUS_OVER_LIM(BUS_OVER_LIM), .BUS_UNDER_LIM(BUS_UNDER_LIM),
        .POWER_LIM(POWER_LIM), .RESULT_VALID(ev[5]), .CURRENT_IN(CURRENT_IN),
        .POWER_IN(POWER_IN), .CONV_START(ev[1]), .CONV_DONE(ev[2]),
        .MATH_OVF_EVT(ev[3]), .CHECKSUM_ERR(ev[4]), .ALERT_O(ALERT_O),
        .ALERT_OE(ALERT_OE));
    pmd_host_model host (.REF_CLK(REF_CLK), .addr(REG_ADDR), .rd(REG_RD),
        .wr(REG_WR), .wdata(REG_WDATA), .rdata(REG_RDATA),
        .rvalid(REG_RVALID));
    // One-cycle strobe on the chosen event inputs
    task automatic fire(input logic [6:0] m);
        @(posedge REF_CLK);
        #1;
        ev = m;
        @(posedge REF_CLK);
        #1;
        ev = 7'h00;
    endtask : fire
    task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    // Pin lags its flag by a cycle, so let two edges pass first
    task automatic chk_alert(input logic exp);
        repeat (2) @(posedge REF_CLK);
        #1;
        checks++;
        if (ALERT_OE !== exp || ALERT_O !== 1'b0) begin
            failures++;
            $display("BAD %0t alert enable %b expected %b", $time, ALERT_OE,
                     exp);
        end
    endtask : chk_alert
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] d;
        host.read_reg(a, d);
        chk_reg(d, exp);
    endtask : rd_chk
    task automatic wr_diag(input logic [23:0] d);
        host.write_reg(PMD_OFS_DIAG, d);
    endtask : wr_diag
    task automatic t_reset;
        rd_chk(PMD_OFS_DIAG, 24'h000001);
        rd_chk(PMD_OFS_CURRENT, 24'h000000);
        rd_chk(PMD_OFS_POWER, 24'h000000);
        rd_chk(6'h3e, 24'h000000);
        chk_alert(1'b0);
        wr_diag(24'hffffff);
        rd_chk(PMD_OFS_DIAG, 24'h00f001);
        chk_alert(1'b1);
        wr_diag(24'h000000);
    endtask : t_reset
    // Each comparator except power in turn, transparent mode
    task automatic t_limits;
        for (int i = 0; i < 5; i++) begin
            {TEMP_RAW, SHUNT_RAW, BUS_RAW} = RAW_TBL[i];
            fire(7'h01);
            rd_chk(PMD_OFS_DIAG, 24'h1 | (24'h80 >> i));
            chk_alert(1'b1);
            {TEMP_RAW, SHUNT_RAW, BUS_RAW} = RAW_NORM;
            fire(7'h01);
            rd_chk(PMD_OFS_DIAG, 24'h000001);
            chk_alert(1'b0);
        end
    endtask : t_limits
    // Latched flags survive the fault going away, cleared by one read
    task automatic t_latch;
        wr_diag(24'h008000);
        CURRENT_IN = 16'h8001;
        POWER_IN = 24'h020000;
        SHUNT_RAW = 16'h0200;
        fire(7'h21);
        SHUNT_RAW = 16'h0000;
        POWER_IN = 24'h000100;
        fire(7'h21);
        chk_alert(1'b1);
        rd_chk(PMD_OFS_CURRENT, 24'h008001);
        rd_chk(PMD_OFS_POWER, 24'h000100);
        POWER_IN = 24'hffffff;
        rd_chk(PMD_OFS_POWER, 24'h000100);
        rd_chk(PMD_OFS_DIAG, 24'h008045);
        rd_chk(PMD_OFS_DIAG, 24'h008001);
        chk_alert(1'b0);
        wr_diag(24'h000000);
    endtask : t_latch
    task automatic t_avg;
        wr_diag(24'h002000);
        TEMP_RAW = 16'h0200;
        fire(7'h01);
        rd_chk(PMD_OFS_DIAG, 24'h002001);
        TEMP_AVG = 16'h0200;
        fire(7'h40);
        rd_chk(PMD_OFS_DIAG, 24'h002081);
        TEMP_AVG = 16'h0000;
        TEMP_RAW = 16'h0000;
        fire(7'h40);
        wr_diag(24'h000000);
    endtask : t_avg
    task automatic t_conv;
        fire(7'h04);
        rd_chk(PMD_OFS_DIAG, 24'h000003);
        chk_alert(1'b0);
        wr_diag(24'h004000);
        chk_alert(1'b1);
        fire(7'h02);
        rd_chk(PMD_OFS_DIAG, 24'h004001);
        wr_diag(24'h00c000);
        fire(7'h04);
        rd_chk(PMD_OFS_DIAG, 24'h00c003);
        rd_chk(PMD_OFS_DIAG, 24'h00c001);
        wr_diag(24'h000000);
    endtask : t_conv
    // Overflow survives reads; the host must start a conversion
    task automatic t_ovf;
        fire(7'h08);
        rd_chk(PMD_OFS_DIAG, 24'h000201);
        rd_chk(PMD_OFS_DIAG, 24'h000201);
        chk_alert(1'b1);
        wr_diag(24'h001000);
        chk_alert(1'b0);
        fire(7'h02);
        rd_chk(PMD_OFS_DIAG, 24'h001001);
        chk_alert(1'b1);
        wr_diag(24'h000000);
        fire(7'h10);
        rd_chk(PMD_OFS_DIAG, 24'h000000);
        chk_alert(1'b1);
    endtask : t_ovf
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    // 250 MHz clock
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    // The whole run is under two hundred cycles; this is ample margin
    initial begin
        #20000;
        failures++;
        test_done();
    end
    // Quiet inputs, reset, then the scenarios
    initial begin
        failures = 0;
        checks = 0;
        NRST = 1'b0;
        ev = 7'h00;
        {TEMP_RAW, SHUNT_RAW, BUS_RAW} = RAW_NORM;
        TEMP_AVG = 16'h0000;
        CURRENT_IN = 16'h0000;
        POWER_IN = 24'h000000;
        {TEMP_LIM, SHUNT_OVER_LIM, SHUNT_UNDER_LIM} = 48'h0100_0100_ff00;
        {BUS_OVER_LIM, BUS_UNDER_LIM, POWER_LIM} = 48'h0100_0010_0100;
        repeat (20) @(posedge REF_CLK);
        #1;
        NRST = 1'b1;
        t_reset();
        t_limits();
        t_latch();
        t_avg();
        t_conv();
        t_ovf();
        test_done();
    end
endmodule : power_monitor_diag_alert_results_test
`default_nettype wire
